// [hw/bwu_top.v]
// Breakpoint and watchpoint comparators with an APB register slave.
// Assumes core event inputs are synchronous to clock, one event per cycle each.
// How it works
// - Control bits 23:16 are per-thread enables; only masked-in threads fire.
// - Control bit 0 enables the comparator; all control fields reset to zero.
// - Four instruction breakpoint control registers at indices 0x40 to 0x43.
// - Instruction control bit 1: zero breaks on PC equal, one on unequal.
// - Four 32-bit first-address registers for the data watchpoints.
// - Four 32-bit second-address registers for the data watchpoints.
// - Data control bit 2 adds loads as triggers; controls at 0x70 to 0x73.
// - Data control bit 1 combines A and B: zero AND, one OR.
// - Four 32-bit resource watchpoint mask registers.
// - Four 32-bit resource watchpoint comparison value registers.
// - Resource control bit 1: zero fires on masked equal, one on unequal; controls at 0x9C to 0x9F.
// - An enabled instruction breakpoint match raises the debug interrupt.
// - Cause code 3 instruction, 4 data, 5 resource watchpoint.
// - Simultaneous hits report instruction, then data, then resource, lowest number within type, plus the causing thread.
// - Data hit captures effective address; resource hit captures resource id.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "bwu_regs.vh"

module bwu_top #(
  parameter THREADS = 8,
  parameter TW      = 3,
  parameter NCMP    = 4
) (
  input  wire        clock,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Instruction issue
  input  wire        pc_valid,
  input  wire [TW-1:0] pc_thread,
  input  wire [31:0] pc,
  // Memory access
  input  wire        mem_valid,
  input  wire        mem_load,
  input  wire [TW-1:0] mem_thread,
  input  wire [31:0] mem_addr,
  // Resource access
  input  wire        res_valid,
  input  wire [TW-1:0] res_thread,
  input  wire [31:0] res_id,
  // Toward core debug logic
  output reg         debug_irq,
  output reg  [2:0]  debug_cause,
  output reg  [1:0]  debug_num,
  output reg  [7:0]  debug_thread,
  output reg  [31:0] debug_data
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  // Flops live per channel below, so each array element has one driver
  wire [31:0] ib_addr  [0:NCMP-1];
  wire [31:0] ib_ctrl  [0:NCMP-1];
  wire [31:0] dw_addr1 [0:NCMP-1];
  wire [31:0] dw_addr2 [0:NCMP-1];
  wire [31:0] dw_ctrl  [0:NCMP-1];
  wire [31:0] rw_mask  [0:NCMP-1];
  wire [31:0] rw_value [0:NCMP-1];
  wire [31:0] rw_ctrl  [0:NCMP-1];

  wire [7:0]  idx      = paddr[9:2];
  wire [5:0]  grp      = idx[7:2];
  wire [1:0]  ch       = idx[1:0];
  wire        wr_en    = psel & penable & pwrite;
  wire        setup    = psel & ~penable;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------

  wire [7:0] b_ib_addr  = `BWU_IDX_IB_ADDR;
  wire [7:0] b_ib_ctrl  = `BWU_IDX_IB_CTRL;
  wire [7:0] b_dw_addr1 = `BWU_IDX_DW_ADDR1;
  wire [7:0] b_dw_addr2 = `BWU_IDX_DW_ADDR2;
  wire [7:0] b_dw_ctrl  = `BWU_IDX_DW_CTRL;
  wire [7:0] b_rw_mask  = `BWU_IDX_RW_MASK;
  wire [7:0] b_rw_value = `BWU_IDX_RW_VALUE;
  wire [7:0] b_rw_ctrl  = `BWU_IDX_RW_CTRL;

  wire hit_ib_addr  = (grp == b_ib_addr[7:2]);
  wire hit_ib_ctrl  = (grp == b_ib_ctrl[7:2]);
  wire hit_dw_addr1 = (grp == b_dw_addr1[7:2]);
  wire hit_dw_addr2 = (grp == b_dw_addr2[7:2]);
  wire hit_dw_ctrl  = (grp == b_dw_ctrl[7:2]);
  wire hit_rw_mask  = (grp == b_rw_mask[7:2]);
  wire hit_rw_value = (grp == b_rw_value[7:2]);
  wire hit_rw_ctrl  = (grp == b_rw_ctrl[7:2]);
  wire hit_type     = (idx == `BWU_IDX_IRQ_TYPE);
  wire hit_data     = (idx == `BWU_IDX_IRQ_DATA);
  wire mapped       = hit_ib_addr | hit_ib_ctrl | hit_dw_addr1 | hit_dw_addr2 |
                      hit_dw_ctrl | hit_rw_mask | hit_rw_value | hit_rw_ctrl |
                      hit_type | hit_data;

  // Zero wait states: read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Only defined control bits are kept, so reserved bits read zero
  localparam [31:0] IB_KEEP = 32'h00FF0003;
  localparam [31:0] DW_KEEP = 32'h00FF0007;
  localparam [31:0] RW_KEEP = 32'h00FF0003;

  // ---------------------------------------------------------------------------
  // Register writes and comparators, one slice per channel
  // ---------------------------------------------------------------------------
  wire [NCMP-1:0] ib_hit;
  wire [NCMP-1:0] dw_hit;
  wire [NCMP-1:0] rw_hit;

  genvar g;
  generate
    for (g = 0; g < NCMP; g = g + 1) begin : g_ch
      wire        this_ch = ({30'h0, ch} == g);
      reg  [31:0] ib_addr_r;
      reg  [31:0] ib_ctrl_r;
      reg  [31:0] dw_addr1_r;
      reg  [31:0] dw_addr2_r;
      reg  [31:0] dw_ctrl_r;
      reg  [31:0] rw_mask_r;
      reg  [31:0] rw_value_r;
      reg  [31:0] rw_ctrl_r;
      wire        ib_eq;
      wire        ib_cond;
      wire        dw_a;
      wire        dw_b;
      wire        dw_kind;
      wire        dw_cond;
      wire        rw_eq;
      wire        rw_cond;

      always @(posedge clock) begin
        if (reset) begin
          ib_addr_r  <= `BWU_DATA_RESET;
          ib_ctrl_r  <= `BWU_CTRL_RESET;
          dw_addr1_r <= `BWU_DATA_RESET;
          dw_addr2_r <= `BWU_DATA_RESET;
          dw_ctrl_r  <= `BWU_CTRL_RESET;
          rw_mask_r  <= `BWU_DATA_RESET;
          rw_value_r <= `BWU_DATA_RESET;
          rw_ctrl_r  <= `BWU_CTRL_RESET;
        end else if (wr_en && this_ch) begin
          if (hit_ib_addr)
            ib_addr_r <= pwdata;
          if (hit_ib_ctrl)
            ib_ctrl_r <= pwdata & IB_KEEP;
          if (hit_dw_addr1)
            dw_addr1_r <= pwdata;
          if (hit_dw_addr2)
            dw_addr2_r <= pwdata;
          if (hit_dw_ctrl)
            dw_ctrl_r <= pwdata & DW_KEEP;
          if (hit_rw_mask)
            rw_mask_r <= pwdata;
          if (hit_rw_value)
            rw_value_r <= pwdata;
          if (hit_rw_ctrl)
            rw_ctrl_r <= pwdata & RW_KEEP;
        end
      end

      // Gathered for the read mux, which indexes by channel
      assign ib_addr[g]  = ib_addr_r;
      assign ib_ctrl[g]  = ib_ctrl_r;
      assign dw_addr1[g] = dw_addr1_r;
      assign dw_addr2[g] = dw_addr2_r;
      assign dw_ctrl[g]  = dw_ctrl_r;
      assign rw_mask[g]  = rw_mask_r;
      assign rw_value[g] = rw_value_r;
      assign rw_ctrl[g]  = rw_ctrl_r;

      // Instruction breakpoint
      assign ib_eq   = (pc == ib_addr_r);
      assign ib_cond = ib_ctrl_r[`BWU_CTRL_SEL_BIT] ? ~ib_eq : ib_eq;

      bwu_cmp #(.THREADS(THREADS), .TW(TW)) u_ib (
        .enable      (ib_ctrl_r[`BWU_CTRL_EN_BIT]),
        .thread_mask (ib_ctrl_r[`BWU_CTRL_MASK_HI:`BWU_CTRL_MASK_LO]),
        .valid       (pc_valid),
        .thread      (pc_thread),
        .cond        (ib_cond),
        .hit         (ib_hit[g])
      );

      // Data watchpoint; stores always count, loads only when asked
      assign dw_a    = (mem_addr == dw_addr1_r);
      assign dw_b    = (mem_addr == dw_addr2_r);
      assign dw_kind = ~mem_load | dw_ctrl_r[`BWU_CTRL_LOAD_BIT];
      assign dw_cond = dw_kind & (dw_ctrl_r[`BWU_CTRL_SEL_BIT] ?
                                  (dw_a | dw_b) : (dw_a & dw_b));

      bwu_cmp #(.THREADS(THREADS), .TW(TW)) u_dw (
        .enable      (dw_ctrl_r[`BWU_CTRL_EN_BIT]),
        .thread_mask (dw_ctrl_r[`BWU_CTRL_MASK_HI:`BWU_CTRL_MASK_LO]),
        .valid       (mem_valid),
        .thread      (mem_thread),
        .cond        (dw_cond),
        .hit         (dw_hit[g])
      );

      // Resource watchpoint
      assign rw_eq   = ((res_id & rw_mask_r) == (rw_value_r & rw_mask_r));
      assign rw_cond = rw_ctrl_r[`BWU_CTRL_SEL_BIT] ? ~rw_eq : rw_eq;

      bwu_cmp #(.THREADS(THREADS), .TW(TW)) u_rw (
        .enable      (rw_ctrl_r[`BWU_CTRL_EN_BIT]),
        .thread_mask (rw_ctrl_r[`BWU_CTRL_MASK_HI:`BWU_CTRL_MASK_LO]),
        .valid       (res_valid),
        .thread      (res_thread),
        .cond        (rw_cond),
        .hit         (rw_hit[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Hit priority: instruction, then data, then resource; lowest number wins
  // ---------------------------------------------------------------------------
  function [1:0] low_num;
    input [3:0] v;
    begin
      if (v[0])
        low_num = 2'h0;
      else if (v[1])
        low_num = 2'h1;
      else if (v[2])
        low_num = 2'h2;
      else
        low_num = 2'h3;
    end
  endfunction

  reg         any_hit;
  reg [2:0]   cause_nxt;
  reg [1:0]   num_nxt;
  reg [7:0]   thr_nxt;
  reg [31:0]  data_nxt;
  reg         data_upd;

  always @* begin
    any_hit   = 1'b1;
    cause_nxt = debug_cause;
    num_nxt   = debug_num;
    thr_nxt   = debug_thread;
    data_nxt  = debug_data;
    data_upd  = 1'b0;
    if (|ib_hit) begin
      cause_nxt = `BWU_CAUSE_INSTR;
      num_nxt   = low_num(ib_hit);
      thr_nxt   = {{(8-TW){1'b0}}, pc_thread};
    end else if (|dw_hit) begin
      cause_nxt = `BWU_CAUSE_DATA;
      num_nxt   = low_num(dw_hit);
      thr_nxt   = {{(8-TW){1'b0}}, mem_thread};
      data_nxt  = mem_addr;
      data_upd  = 1'b1;
    end else if (|rw_hit) begin
      cause_nxt = `BWU_CAUSE_RES;
      num_nxt   = low_num(rw_hit);
      thr_nxt   = {{(8-TW){1'b0}}, res_thread};
      data_nxt  = res_id;
      data_upd  = 1'b1;
    end else begin
      any_hit   = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt and capture registers; a hit wins over a software write
  // ---------------------------------------------------------------------------
  wire wr_type = wr_en & hit_type;
  wire wr_data = wr_en & hit_data;

  always @(posedge clock) begin
    if (reset) begin
      debug_irq    <= 1'b0;
      debug_cause  <= 3'h0;
      debug_num    <= 2'h0;
      debug_thread <= 8'h00;
      debug_data   <= `BWU_DATA_RESET;
    end else begin
      debug_irq <= any_hit;
      if (any_hit) begin
        debug_cause  <= cause_nxt;
        debug_num    <= num_nxt;
        debug_thread <= thr_nxt;
      end else if (wr_type) begin
        debug_cause  <= pwdata[2:0];
        debug_num    <= pwdata[`BWU_TYPE_NUM_HI:`BWU_TYPE_NUM_LO];
        debug_thread <= pwdata[`BWU_TYPE_THR_HI:`BWU_TYPE_THR_LO];
      end
      if (data_upd)
        debug_data <= data_nxt;
      else if (wr_data)
        debug_data <= pwdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data, latched in the setup cycle
  // ---------------------------------------------------------------------------
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h00000000;
    if (hit_ib_addr)
      rd_nxt = ib_addr[ch];
    else if (hit_ib_ctrl)
      rd_nxt = ib_ctrl[ch];
    else if (hit_dw_addr1)
      rd_nxt = dw_addr1[ch];
    else if (hit_dw_addr2)
      rd_nxt = dw_addr2[ch];
    else if (hit_dw_ctrl)
      rd_nxt = dw_ctrl[ch];
    else if (hit_rw_mask)
      rd_nxt = rw_mask[ch];
    else if (hit_rw_value)
      rd_nxt = rw_value[ch];
    else if (hit_rw_ctrl)
      rd_nxt = rw_ctrl[ch];
    else if (hit_type)
      rd_nxt = {14'h0000, debug_num, debug_thread, 5'h00, debug_cause};
    else if (hit_data)
      rd_nxt = debug_data;
  end

  always @(posedge clock) begin
    if (reset)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= rd_nxt;
  end

endmodule // bwu_top

// [shared/bwu_regs.vh]
// Register indices, field positions and reset values of the breakpoint unit.
// Assumes byte address = 4 * index on a 32-bit APB bus.
`ifndef BWU_REGS_VH
`define BWU_REGS_VH

// ---------------------------------------------------------------------------
// Register indices (word numbers)
// ---------------------------------------------------------------------------
`define BWU_IDX_IRQ_TYPE      8'h15
`define BWU_IDX_IRQ_DATA      8'h16
`define BWU_IDX_IB_ADDR       8'h30
`define BWU_IDX_IB_CTRL       8'h40
`define BWU_IDX_DW_ADDR1      8'h50
`define BWU_IDX_DW_ADDR2      8'h60
`define BWU_IDX_DW_CTRL       8'h70
`define BWU_IDX_RW_MASK       8'h80
`define BWU_IDX_RW_VALUE      8'h90
`define BWU_IDX_RW_CTRL       8'h9C

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define BWU_CTRL_EN_BIT       0
`define BWU_CTRL_SEL_BIT      1
`define BWU_CTRL_LOAD_BIT     2
`define BWU_CTRL_MASK_HI      23
`define BWU_CTRL_MASK_LO      16
`define BWU_CTRL_RESET        32'h00000000
`define BWU_DATA_RESET        32'h00000000

// ---------------------------------------------------------------------------
// Interrupt type fields and cause codes
// ---------------------------------------------------------------------------
`define BWU_TYPE_NUM_HI       17
`define BWU_TYPE_NUM_LO       16
`define BWU_TYPE_THR_HI       15
`define BWU_TYPE_THR_LO       8
`define BWU_CAUSE_INSTR       3'h3
`define BWU_CAUSE_DATA        3'h4
`define BWU_CAUSE_RES         3'h5

`endif

// [hw/bwu_cmp.v]
// One comparator qualifier: master enable and per-thread mask.
// Assumes the match condition is already formed by the caller.
`timescale 1ns/10ps

module bwu_cmp #(
  parameter THREADS = 8,
  parameter TW      = 3
) (
  input  wire               enable,
  input  wire [THREADS-1:0] thread_mask,
  input  wire               valid,
  input  wire [TW-1:0]      thread,
  input  wire               cond,
  output wire               hit
);

  // Master enable and thread mask gate the condition
  assign hit = enable & thread_mask[thread] & valid & cond;

endmodule // bwu_cmp

// [verification/bwu_top_sva.sv]
// Port assertions for the breakpoint unit.
// Assumes binding to bwu_top; one clock, synchronous reset.
`timescale 1ns/10ps
module bwu_chk #(parameter THREADS = 8, parameter TW = 3) (
  input wire          clock,
  input wire          reset,
  input wire          psel,
  input wire          penable,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire          pc_valid,
  input wire [TW-1:0] pc_thread,
  input wire          mem_valid,
  input wire [TW-1:0] mem_thread,
  input wire [31:0]   mem_addr,
  input wire          res_valid,
  input wire [TW-1:0] res_thread,
  input wire [31:0]   res_id,
  input wire          debug_irq,
  input wire [2:0]    debug_cause,
  input wire [7:0]    debug_thread,
  input wire [31:0]   debug_data
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access not answered");
  AST_ERR: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  AST_HOLD: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved");
  AST_CAUSE: assert property (debug_irq |-> debug_cause inside {3'h3, 3'h4, 3'h5})
    else $error("bad cause");
  AST_INSTR: assert property (debug_irq && debug_cause == 3'h3 |->
    $past(pc_valid) && debug_thread == 8'($past(pc_thread)))
    else $error("instr hit without issue");
  AST_DATA: assert property (debug_irq && debug_cause == 3'h4 |->
    $past(mem_valid) && debug_data == $past(mem_addr) &&
    debug_thread == 8'($past(mem_thread)))
    else $error("data capture wrong");
  AST_RES: assert property (debug_irq && debug_cause == 3'h5 |->
    $past(res_valid) && debug_data == $past(res_id) &&
    debug_thread == 8'($past(res_thread)))
    else $error("resource capture wrong");
  AST_QUIET: assert property (!pc_valid && !mem_valid && !res_valid |=> !debug_irq)
    else $error("irq without event");
  COV_I: cover property (debug_irq && debug_cause == 3'h3);
  COV_D: cover property (debug_irq && debug_cause == 3'h4);
  COV_R: cover property (debug_irq && debug_cause == 3'h5);
endmodule // bwu_chk

bind bwu_top bwu_chk #(.THREADS(THREADS), .TW(TW)) u_chk (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc_valid(pc_valid), .pc_thread(pc_thread),
  .mem_valid(mem_valid), .mem_thread(mem_thread), .mem_addr(mem_addr),
  .res_valid(res_valid), .res_thread(res_thread), .res_id(res_id),
  .debug_irq(debug_irq), .debug_cause(debug_cause), .debug_thread(debug_thread),
  .debug_data(debug_data));

// [verification/bwu_sw_model.sv]
// Debug software model: APB master for register transfers.
// Assumes tasks are called by the bench; clock runs freely.
`timescale 1ns/10ps
module bwu_sw (
  input wire          clock,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire   [31:0] prdata,
  input wire          pready,
  input wire          pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  // ----------------------------------------
  // Transfer: waits on pready, no fixed latency assumed
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale bus values hidden once released
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // bwu_sw

// [verification/test_bwu_top.sv]
// Random bench for bwu_top: register mix plus core events.
// Assumes bwu_sw drives the register bus; expectations from a bench model.
`timescale 1ns/10ps
`include "bwu_regs.vh"
module test_bwu_top;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, e, e_irq;
  logic        pc_valid, mem_valid, mem_load, res_valid, debug_irq;
  logic [31:0] paddr, pwdata, prdata, pc, mem_addr, res_id, debug_data, q, r, e_data;
  logic [2:0]  pc_thread, mem_thread, res_thread, debug_cause, e_cause;
  logic [1:0]  debug_num, e_num;
  logic [7:0]  debug_thread, e_thr;
  logic [31:0] m [0:255];
  logic [31:0] s = 32'h960BEFBD;
  int          n_mismatch, checks, i, k;

  bwu_top dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_valid(pc_valid), .pc_thread(pc_thread), .pc(pc),
    .mem_valid(mem_valid), .mem_load(mem_load), .mem_thread(mem_thread),
    .mem_addr(mem_addr), .res_valid(res_valid), .res_thread(res_thread), .res_id(res_id),
    .debug_irq(debug_irq), .debug_cause(debug_cause), .debug_num(debug_num),
    .debug_thread(debug_thread), .debug_data(debug_data));
  bwu_sw sw (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Helpers and reference model
  // ----------------------------------------
  function automatic logic [31:0] xrand();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [7:0] pick(input logic [4:0] n);
    logic [7:0] b [0:7] = '{`BWU_IDX_IB_ADDR, `BWU_IDX_IB_CTRL, `BWU_IDX_DW_ADDR1,
      `BWU_IDX_DW_ADDR2, `BWU_IDX_DW_CTRL, `BWU_IDX_RW_MASK, `BWU_IDX_RW_VALUE, `BWU_IDX_RW_CTRL};
    return b[n[4:2]] + {6'h0, n[1:0]};
  endfunction
  function automatic logic [31:0] wmask(input logic [7:0] x);
    if (x[7:2] == 6'h1C) return 32'h00FF0007;
    if (x[7:2] == 6'h10 || x[7:2] == 6'h27) return 32'h00FF0003;
    if (x == 8'hA0) return 32'h0;
    return 32'hFFFFFFFF;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hit(input logic [2:0] c, input int n, input logic [2:0] t, input logic [31:0] d);
    e_irq = 1'b1;
    e_cause = c;
    e_num = n[1:0];
    e_thr = {5'h0, t};
    e_data = d;
  endtask
  task automatic predict();
    logic a, b;
    logic [31:0] cr, d0;
    d0 = e_data;
    e_irq = 1'b0;
    for (k = 3; k >= 0; k--) begin
      cr = m[`BWU_IDX_RW_CTRL+k];
      a = (res_id & m[`BWU_IDX_RW_MASK+k]) == (m[`BWU_IDX_RW_VALUE+k] & m[`BWU_IDX_RW_MASK+k]);
      if (res_valid && cr[0] && cr[16+res_thread] && (cr[1] ? !a : a)) hit(3'h5, k, res_thread, res_id);
    end
    for (k = 3; k >= 0; k--) begin
      cr = m[`BWU_IDX_DW_CTRL+k];
      a = mem_addr == m[`BWU_IDX_DW_ADDR1+k];
      b = mem_addr == m[`BWU_IDX_DW_ADDR2+k];
      if (mem_valid && cr[0] && cr[16+mem_thread] && (!mem_load || cr[2]) && (cr[1] ? a | b : a & b))
        hit(3'h4, k, mem_thread, mem_addr);
    end
    for (k = 3; k >= 0; k--) begin
      cr = m[`BWU_IDX_IB_CTRL+k];
      if (pc_valid && cr[0] && cr[16+pc_thread] && ((pc == m[`BWU_IDX_IB_ADDR+k]) ^ cr[1]))
        hit(3'h3, k, pc_thread, d0);
    end
  endtask
  task automatic wr(input logic [7:0] x);
    r = xrand();
    if (r[31:30] != 2'h0 && wmask(x) == 32'hFFFFFFFF) r = r & 32'h3;
    sw.xfer(1'b1, x, r, q, e);
    m[x] = r & wmask(x);
    sw.xfer(1'b0, x, 32'h0, q, e);
    check(q, m[x]);
    check({31'h0, e}, {31'h0, wmask(x) == 32'h0});
  endtask
  task automatic ev();
    r = xrand();
    @(posedge clock);
    {pc_valid, mem_valid, res_valid, mem_load} <= {r[0], r[21], r[22], r[11]};
    {pc_thread, mem_thread, res_thread} <= r[20:12];
    pc <= {30'h0, r[24:23]};
    mem_addr <= {30'h0, r[10:9]};
    res_id <= r[6] ? xrand() : {30'h0, r[8:7]};
    @(posedge clock);
    predict();
    {pc_valid, mem_valid, res_valid} <= 3'h0;
    #1;
    check(debug_irq, e_irq);
    check(debug_cause, e_cause);
    check({debug_num, debug_thread}, {e_num, e_thr});
    check(debug_data, e_data);
  endtask
  task automatic irq_regs();
    sw.xfer(1'b0, `BWU_IDX_IRQ_TYPE, 32'h0, q, e);
    check(q, {14'h0, e_num, e_thr, 5'h0, e_cause});
    sw.xfer(1'b0, `BWU_IDX_IRQ_DATA, 32'h0, q, e);
    check(q, e_data);
    r = xrand();
    sw.xfer(1'b1, r[3] ? `BWU_IDX_IRQ_TYPE : `BWU_IDX_IRQ_DATA, r, q, e);
    if (r[3]) {e_num, e_thr, e_cause} = {r[17:8], r[2:0]};
    else e_data = r;
  endtask
  task automatic reset_and_read();
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 32; i++) begin
      sw.xfer(1'b0, pick(i[4:0]), 32'h0, q, e);
      check(q, 32'h0);
    end
    check({debug_irq, debug_cause, debug_num, debug_thread}, 32'h0);
    check(debug_data, 32'h0);
    {e_irq, e_cause, e_num, e_thr, e_data} = '0;
    for (i = 0; i < 256; i++) m[i] = 32'h0;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (50000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {reset, pc_valid, mem_valid, res_valid, mem_load} = 5'h10;
    {pc_thread, mem_thread, res_thread, pc, mem_addr, res_id} = '0;
    reset_and_read();
    for (i = 0; i < 32; i++) wr(pick(i[4:0]));
    for (i = 0; i < 500; i++) begin
      r = xrand();
      if (r[1:0] == 2'h0) wr(r[9:6] == 4'h0 ? 8'hA0 : pick(r[14:10]));
      else if (r[4:2] == 3'h0) irq_regs();
      ev();
    end
    // Closing reset after the random loop must clear every register again
    @(posedge clock);
    reset_and_read();
    give_verdict();
  end
endmodule // test_bwu_top
